// [rtl/tlie_pkg.sv]
// tlie_pkg: constants for the timer and logic instruction execute block.
// assumes 10-bit instruction words and a combinational register file and program memory.
package tlie_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ROM_PAGE_BITS = 3;                  // page bits used of rom_page_ctrl
	localparam int ROM_ADDR_W    = ROM_PAGE_BITS + 8;  // page bits above the base pair

	// ------------------------------------------------------------
	// fixed opcodes, 10-bit internal form
	// ------------------------------------------------------------
	localparam logic [9:0] OP_RD_TIMER_LO  = 10'h3FF;
	localparam logic [9:0] OP_RD_TIMER_HI  = 10'h3DF;
	localparam logic [9:0] OP_RD_MOD_A_LO  = 10'h3F6;
	localparam logic [9:0] OP_RD_MOD_A_HI  = 10'h3D6;
	localparam logic [9:0] OP_RD_MOD_B_LO  = 10'h3F7;
	localparam logic [9:0] OP_RD_MOD_B_HI  = 10'h3D7;
	localparam logic [9:0] OP_WR_TIMER_LO  = 10'h0BF;
	localparam logic [9:0] OP_WR_TIMER_HI  = 10'h29F;
	localparam logic [9:0] OP_WR_MOD_A_LO  = 10'h0B6;
	localparam logic [9:0] OP_WR_MOD_A_HI  = 10'h096;
	localparam logic [9:0] OP_WR_MOD_B_LO  = 10'h0B7;
	localparam logic [9:0] OP_WR_MOD_B_HI  = 10'h097;
	localparam logic [9:0] OP_LD_TIMER_IMM = 10'h0DF;
	localparam logic [9:0] OP_LD_MOD_A_IMM = 10'h0D6;
	localparam logic [9:0] OP_LD_MOD_B_IMM = 10'h0D7;
	localparam logic [9:0] OP_LD_TIMER_TBL = 10'h0FF;
	localparam logic [9:0] OP_LD_MOD_A_TBL = 10'h0F6;
	localparam logic [9:0] OP_LD_MOD_B_TBL = 10'h0F7;
	localparam logic [9:0] OP_STANDBY      = 10'h051;
	localparam logic [9:0] OP_STAT_IMM     = 10'h071;
	localparam logic [9:0] OP_STAT_REG     = 10'h060;  // low nibble is the register index
	localparam logic [9:0] OP_ALL_ONES     = 10'h353;
	localparam logic [9:0] OP_NOP          = 10'h000;

	// ------------------------------------------------------------
	// logic-op groups: bits 9..6 select the operation
	// ------------------------------------------------------------
	localparam logic [3:0] GRP_AND = 4'hD;
	localparam logic [3:0] GRP_OR  = 4'hE;
	localparam logic [3:0] GRP_XOR = 4'hA;
	localparam logic [4:0] SUB_ROM = 5'h10;            // bits 4..0 of the memory form
	localparam logic [4:0] SUB_IMM = 5'h11;            // bits 4..0 of the immediate form
	localparam logic [3:0] ALL_ONES = 4'hF;

	// ------------------------------------------------------------
	// software port map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL  = 4'h0;
	localparam logic [3:0] ADDR_ACC   = 4'h1;
	localparam logic [3:0] ADDR_FLAGS = 4'h2;
	localparam logic [3:0] ADDR_TIMER = 4'h3;
	localparam logic [3:0] ADDR_MOD_A = 4'h4;
	localparam logic [3:0] ADDR_MOD_B = 4'h5;
	localparam logic [1:0] CTRL_RESET = 2'h1;          // execute enabled, exact status match
	localparam int         CTRL_EXEC_BIT = 0;
	localparam int         CTRL_ANY_BIT  = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] ACC_RESET = 4'h0;
	localparam logic [9:0] T10_RESET = 10'h000;

	typedef enum {EX_IDLE, EX_STANDBY} tlie_mode_t;

endpackage

// [rtl/tlie_exec.sv]
// tlie_exec: executes the timer transfer, misc and logic instructions of a 4-bit core.
// assumes one instruction per cycle with its second word beside it, a register file and
// program memory that answer combinationally in the same cycle, and a status input from pins.
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

module tlie_exec
	import tlie_pkg::*;
(
	// clock and reset
	input  wire logic                  I_SYS_CLK,
	input  wire logic                  I_RESET,
	// instruction issue
	input  wire logic                  I_INSTR_VALID,
	input  wire logic [9:0]            I_INSTR_WORD,
	input  wire logic [9:0]            I_SECOND_WORD,
	// register file read
	output logic      [4:0]            O_REG_RADDR,
	input  wire logic [3:0]            I_REG_RDATA,
	// program memory table read
	input  wire logic [3:0]            I_ROM_PAGE_CTRL,
	input  wire logic [7:0]            I_TABLE_BASE_PAIR,
	output logic      [ROM_ADDR_W-1:0] O_ROM_ADDR,
	input  wire logic [9:0]            I_ROM_DATA,
	// external status and wake
	input  wire logic [3:0]            I_STATUS,
	input  wire logic                  I_WAKEUP,
	// software port
	input  wire logic [3:0]            I_SW_ADDR,
	input  wire logic [15:0]           I_SW_WDATA,
	input  wire logic                  I_SW_WR,
	input  wire logic                  I_SW_RD,
	output logic      [15:0]           O_SW_RDATA,
	// core state
	output logic      [3:0]            O_ACC,
	output logic                       O_CARRY,
	output logic                       O_STATUS_FLAG,
	output logic      [9:0]            O_TIMER,
	output logic      [9:0]            O_MOD_A,
	output logic      [9:0]            O_MOD_B,
	// sequencing
	output logic                       O_DONE,
	output logic      [1:0]            O_PC_STEP,
	output logic                       O_UNKNOWN,
	output logic                       O_STANDBY,
	output logic      [3:0]            O_STANDBY_COND
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [3:0]  acc;
	logic        carry_flag;
	logic        status_flag;
	logic [9:0]  timer;
	logic [9:0]  mod_reg_a;
	logic [9:0]  mod_reg_b;
	logic [1:0]  ctrl;
	tlie_mode_t  mode;
	logic [3:0]  standby_cond;
	logic [2:0]  status_sync [0:3];
	logic [3:0]  status_clean;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic        fire;
	logic [3:0]  grp;
	logic        is_logic;
	logic        is_reg_form;
	logic        is_rom_form;
	logic        is_imm_form;
	logic [3:0]  rom_nib;
	logic [3:0]  operand;
	logic        operand_b3;
	logic [3:0]  next_acc;
	logic        next_carry;
	logic        acc_we;
	logic        carry_we;
	logic        known;
	logic        two_word;
	logic        stat_match;
	logic [3:0]  stat_operand;

	// standby halts issue; software can also gate execution off
	assign fire        = I_INSTR_VALID && ctrl[CTRL_EXEC_BIT] && (mode == EX_IDLE);
	assign grp         = I_INSTR_WORD[9:6];
	assign is_logic    = (grp == GRP_AND) || (grp == GRP_OR) || (grp == GRP_XOR);
	assign is_reg_form = is_logic && !I_INSTR_WORD[4];
	assign is_rom_form = is_logic && (I_INSTR_WORD[4:0] == SUB_ROM);
	assign is_imm_form = is_logic && I_INSTR_WORD[5] && (I_INSTR_WORD[4:0] == SUB_IMM);

	// bank 0 is coded with R4 set; index straight from the low bits
	assign O_REG_RADDR = {~I_INSTR_WORD[5], I_INSTR_WORD[3:0]};

	// page bits sit above the eight base-pair bits
	assign O_ROM_ADDR = {I_ROM_PAGE_CTRL[ROM_PAGE_BITS-1:0], I_TABLE_BASE_PAIR};

	// ------------------------------------------------------------
	// status input synchroniser, three stages per bit
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_stat
			always_ff @(posedge I_SYS_CLK) begin
				if (I_RESET) begin
					status_sync[gi]  <= 3'h0;
					status_clean[gi] <= 1'b0;
				end else begin
					status_sync[gi] <= {status_sync[gi][1:0], I_STATUS[gi]};
					// only a level that stage two and three agree on is taken
					if (status_sync[gi][1] == status_sync[gi][2]) begin
						status_clean[gi] <= status_sync[gi][2];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// logic operand and result
	// ------------------------------------------------------------
	always_comb begin
		// memory form: bit5 clear picks b7..b4, set picks b3..b0; b9 and b8 never reach acc
		rom_nib    = I_INSTR_WORD[5] ? I_ROM_DATA[3:0] : I_ROM_DATA[7:4];
		operand    = I_REG_RDATA;
		if (is_rom_form) begin
			operand = rom_nib;
		end else if (is_imm_form) begin
			operand = I_SECOND_WORD[3:0];
		end
		operand_b3 = operand[3];
	end

	// status test compare, exact or any-common-bit as software chooses
	assign stat_operand = (I_INSTR_WORD == OP_STAT_IMM) ? I_SECOND_WORD[3:0] : I_REG_RDATA;
	assign stat_match   = ctrl[CTRL_ANY_BIT] ? ((status_clean & stat_operand) != 4'h0)
	                                         : (status_clean == stat_operand);

	// ------------------------------------------------------------
	// main execute decode
	// ------------------------------------------------------------
	always_comb begin
		next_acc   = acc;
		next_carry = carry_flag;
		acc_we     = 1'b0;
		carry_we   = 1'b0;
		known      = 1'b1;
		two_word   = 1'b0;
		if (is_logic && (is_reg_form || is_rom_form || is_imm_form)) begin
			acc_we   = 1'b1;
			carry_we = 1'b1;
			two_word = is_imm_form;
			case (grp)
				GRP_AND: begin
					next_acc   = acc & operand;
					next_carry = acc[3] & operand_b3;
				end
				GRP_OR: begin
					next_acc   = acc | operand;
					next_carry = 1'b0;
				end
				GRP_XOR: begin
					next_acc   = acc ^ operand;
					next_carry = acc[3] & operand_b3;
				end
				default: known = 1'b0;
			endcase
			// only the register form of xor is handled here
			if ((grp == GRP_XOR) && !is_reg_form) begin
				acc_we   = 1'b0;
				carry_we = 1'b0;
				known    = 1'b0;
			end
		end else begin
			case (I_INSTR_WORD)
				OP_RD_TIMER_LO, OP_RD_TIMER_HI, OP_RD_MOD_A_LO, OP_RD_MOD_A_HI,
				OP_RD_MOD_B_LO, OP_RD_MOD_B_HI: begin
					case (I_INSTR_WORD)
						OP_RD_TIMER_LO: next_acc = timer[3:0];
						OP_RD_TIMER_HI: next_acc = timer[7:4];
						OP_RD_MOD_A_LO: next_acc = mod_reg_a[3:0];
						OP_RD_MOD_A_HI: next_acc = mod_reg_a[7:4];
						OP_RD_MOD_B_LO: next_acc = mod_reg_b[3:0];
						default:        next_acc = mod_reg_b[7:4];
					endcase
					acc_we     = 1'b1;
					carry_we   = 1'b1;
					next_carry = 1'b0;
				end
				OP_WR_MOD_A_LO, OP_WR_MOD_A_HI, OP_WR_MOD_B_LO, OP_WR_MOD_B_HI: begin
					carry_we   = 1'b1;
					next_carry = 1'b0;
				end
				OP_WR_TIMER_LO, OP_WR_TIMER_HI, OP_LD_TIMER_TBL, OP_LD_MOD_A_TBL,
				OP_LD_MOD_B_TBL, OP_NOP: known = 1'b1;
				OP_LD_TIMER_IMM, OP_LD_MOD_A_IMM, OP_LD_MOD_B_IMM, OP_STANDBY, OP_STAT_IMM: begin
					two_word = 1'b1;
				end
				OP_ALL_ONES: begin
					carry_we   = 1'b1;
					next_carry = (acc == ALL_ONES);
				end
				default: begin
					// bank-0 status test carries its register index in the low nibble
					known = (I_INSTR_WORD[9:4] == OP_STAT_REG[9:4]);
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// accumulator and carry; software writes lose to an executing instruction that writes that register
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			acc <= ACC_RESET;
		end else if (fire && acc_we) begin
			acc <= next_acc;
		end else if (I_SW_WR && (I_SW_ADDR == ADDR_ACC)) begin
			acc <= I_SW_WDATA[3:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			carry_flag <= 1'b0;
		end else if (fire && carry_we) begin
			carry_flag <= next_carry;
		end else if (I_SW_WR && (I_SW_ADDR == ADDR_FLAGS)) begin
			carry_flag <= I_SW_WDATA[0];
		end
	end

	// status flag follows every status test
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			status_flag <= 1'b0;
		end else if (fire && ((I_INSTR_WORD == OP_STAT_IMM)
		             || (I_INSTR_WORD[9:4] == OP_STAT_REG[9:4]))) begin
			status_flag <= stat_match;
		end else if (I_SW_WR && (I_SW_ADDR == ADDR_FLAGS)) begin
			status_flag <= I_SW_WDATA[1];
		end
	end

	// ------------------------------------------------------------
	// timer and modulation registers; bits 9..8 kept on nibble writes
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			timer <= T10_RESET;
		end else if (fire) begin
			case (I_INSTR_WORD)
				OP_WR_TIMER_LO:  timer[3:0] <= acc;
				OP_WR_TIMER_HI:  timer[7:4] <= acc;
				OP_LD_TIMER_IMM: timer      <= I_SECOND_WORD;
				OP_LD_TIMER_TBL: timer      <= I_ROM_DATA;
				default:         timer      <= timer;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			mod_reg_a <= T10_RESET;
		end else if (fire) begin
			case (I_INSTR_WORD)
				OP_WR_MOD_A_LO:  mod_reg_a[3:0] <= acc;
				OP_WR_MOD_A_HI:  mod_reg_a[7:4] <= acc;
				OP_LD_MOD_A_IMM: mod_reg_a      <= I_SECOND_WORD;
				OP_LD_MOD_A_TBL: mod_reg_a      <= I_ROM_DATA;
				default:         mod_reg_a      <= mod_reg_a;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			mod_reg_b <= T10_RESET;
		end else if (fire) begin
			case (I_INSTR_WORD)
				OP_WR_MOD_B_LO:  mod_reg_b[3:0] <= acc;
				OP_WR_MOD_B_HI:  mod_reg_b[7:4] <= acc;
				OP_LD_MOD_B_IMM: mod_reg_b      <= I_SECOND_WORD;
				OP_LD_MOD_B_TBL: mod_reg_b      <= I_ROM_DATA;
				default:         mod_reg_b      <= mod_reg_b;
			endcase
		end
	end

	// ------------------------------------------------------------
	// standby mode: left on the wake input
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			mode         <= EX_IDLE;
			standby_cond <= 4'h0;
		end else begin
			case (mode)
				EX_IDLE: begin
					if (fire && (I_INSTR_WORD == OP_STANDBY)) begin
						mode         <= EX_STANDBY;
						standby_cond <= I_SECOND_WORD[3:0];
					end
				end
				EX_STANDBY: begin
					if (I_WAKEUP) begin
						mode <= EX_IDLE;
					end
				end
				default: mode <= EX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// completion, one cycle per instruction
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_DONE    <= 1'b0;
			O_PC_STEP <= 2'h0;
			O_UNKNOWN <= 1'b0;
		end else begin
			O_DONE    <= fire && known;
			O_UNKNOWN <= fire && !known;
			// nop touches nothing else and steps by one
			O_PC_STEP <= (fire && known) ? (two_word ? 2'h2 : 2'h1) : 2'h0;
		end
	end

	// ------------------------------------------------------------
	// software port: control and state readback, one cycle latency
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ctrl <= CTRL_RESET;
		end else if (I_SW_WR && (I_SW_ADDR == ADDR_CTRL)) begin
			ctrl <= I_SW_WDATA[1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_SW_RDATA <= 16'h0000;
		end else if (I_SW_RD) begin
			case (I_SW_ADDR)
				ADDR_CTRL:  O_SW_RDATA <= {14'h0000, ctrl};
				ADDR_ACC:   O_SW_RDATA <= {12'h000, acc};
				ADDR_FLAGS: O_SW_RDATA <= {13'h0000, (mode == EX_STANDBY), status_flag, carry_flag};
				ADDR_TIMER: O_SW_RDATA <= {6'h00, timer};
				ADDR_MOD_A: O_SW_RDATA <= {6'h00, mod_reg_a};
				ADDR_MOD_B: O_SW_RDATA <= {6'h00, mod_reg_b};
				default:    O_SW_RDATA <= 16'h0000;
			endcase
		end else begin
			O_SW_RDATA <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// state outputs
	// ------------------------------------------------------------
	assign O_ACC          = acc;
	assign O_CARRY        = carry_flag;
	assign O_STATUS_FLAG  = status_flag;
	assign O_TIMER        = timer;
	assign O_MOD_A        = mod_reg_a;
	assign O_MOD_B        = mod_reg_b;
	assign O_STANDBY      = (mode == EX_STANDBY);
	assign O_STANDBY_COND = standby_cond;

endmodule // tlie_exec

// [bench/tlie_mem_model.sv]
// tlie_mem_model: register file and program memory beside the execute block.
// assumes both answer combinationally, as the core samples them in the same cycle.
`timescale 1ns/10ps
module tlie_mem_model
	import tlie_pkg::*;
(
	// register file
	input  wire logic [4:0]            i_reg_raddr,
	output logic      [3:0]            o_reg_rdata,
	// program memory
	input  wire logic [ROM_ADDR_W-1:0] i_rom_addr,
	output logic      [9:0]            o_rom_data
);
	// fixed patterns stand in for contents, so no loading is needed
	assign o_reg_rdata = 4'(i_reg_raddr * 5'h05 + 5'h03);
	assign o_rom_data  = 10'(i_rom_addr * 11'h025 + 11'h00B); // full ten-bit words
endmodule // tlie_mem_model

// [bench/tlie_exec_properties.sv]
// tlie_exec_properties: timing relations on the execute block ports.
// assumes execution enable changes only through software writes to the control word.
`timescale 1ns/10ps
module tlie_exec_properties
	import tlie_pkg::*;
(
	// clock and reset
	input wire logic                  I_SYS_CLK,
	input wire logic                  I_RESET,
	// watched inputs
	input wire logic                  I_INSTR_VALID,
	input wire logic [9:0]            I_INSTR_WORD,
	input wire logic [9:0]            I_SECOND_WORD,
	input wire logic [3:0]            I_REG_RDATA,
	input wire logic [3:0]            I_ROM_PAGE_CTRL,
	input wire logic [7:0]            I_TABLE_BASE_PAIR,
	input wire logic [9:0]            I_ROM_DATA,
	input wire logic [3:0]            I_SW_ADDR,
	input wire logic [15:0]           I_SW_WDATA,
	input wire logic                  I_SW_WR,
	// watched outputs
	input wire logic [4:0]            O_REG_RADDR,
	input wire logic [ROM_ADDR_W-1:0] O_ROM_ADDR,
	input wire logic [3:0]            O_ACC,
	input wire logic                  O_CARRY,
	input wire logic [9:0]            O_TIMER,
	input wire logic [9:0]            O_MOD_A,
	input wire logic [9:0]            O_MOD_B,
	input wire logic                  O_DONE,
	input wire logic [1:0]            O_PC_STEP,
	input wire logic                  O_STANDBY,
	input wire logic [3:0]            O_STANDBY_COND
);
	logic       exec_on;
	wire  [9:0] w = I_INSTR_WORD;
	// a request fires only when execution is on and the core is awake
	wire        f = I_INSTR_VALID && exec_on && !O_STANDBY;

	// mirror of the enable bit, since it is not visible at the ports
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET)
			exec_on <= CTRL_RESET[CTRL_EXEC_BIT];
		else if (I_SW_WR && I_SW_ADDR == ADDR_CTRL)
			exec_on <= I_SW_WDATA[CTRL_EXEC_BIT];
	end

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);

	chk_rd_timer_nib: assert property (f && w == OP_RD_TIMER_HI |=>
		O_ACC == $past(O_TIMER[7:4]) && !O_CARRY && O_PC_STEP == 2'h1) else $error("timer read");
	chk_rd_mod_nib: assert property (f && w == OP_RD_MOD_A_LO |=>
		O_ACC == $past(O_MOD_A[3:0]) && !O_CARRY) else $error("mod read");
	chk_wr_mod_nib: assert property (f && w == OP_WR_MOD_B_HI |=> O_MOD_B[7:4] == $past(O_ACC)
		&& O_MOD_B[9:8] == $past(O_MOD_B[9:8]) && !O_CARRY) else $error("mod write");
	chk_imm_timer: assert property (f && w == OP_LD_TIMER_IMM |=>
		O_TIMER == $past(I_SECOND_WORD) && O_DONE && O_PC_STEP == 2'h2) else $error("timer imm");
	chk_tbl_addr: assert property (
		O_ROM_ADDR == {I_ROM_PAGE_CTRL[ROM_PAGE_BITS-1:0], I_TABLE_BASE_PAIR}) else $error("rom addr");
	chk_tbl_load: assert property (f && w == OP_LD_MOD_A_TBL |=>
		O_MOD_A == $past(I_ROM_DATA)) else $error("table load");
	chk_standby_in: assert property (f && w == OP_STANDBY |=>
		O_STANDBY && O_STANDBY_COND == $past(I_SECOND_WORD[3:0])) else $error("standby");
	chk_all_ones: assert property (f && w == OP_ALL_ONES |=>
		O_CARRY == ($past(O_ACC) == ALL_ONES)) else $error("all ones");
	chk_nop_only: assert property (f && w == OP_NOP && !I_SW_WR |=> O_PC_STEP == 2'h1
		&& $stable(O_ACC) && $stable(O_TIMER) && $stable(O_CARRY)) else $error("nop");
	chk_and_reg: assert property (f && w[9:6] == GRP_AND && !w[4] |=>
		O_ACC == $past(O_ACC & I_REG_RDATA) && O_CARRY == $past(O_ACC[3] & I_REG_RDATA[3]))
		else $error("and reg");
	chk_or_imm: assert property (f && w == {GRP_OR, 1'b1, SUB_IMM} |=>
		O_ACC == $past(O_ACC | I_SECOND_WORD[3:0]) && !O_CARRY) else $error("or imm");
	chk_xor_reg: assert property (f && w[9:6] == GRP_XOR && !w[4] |=>
		O_ACC == $past(O_ACC ^ I_REG_RDATA) && O_CARRY == $past(O_ACC[3] & I_REG_RDATA[3]))
		else $error("xor reg");
	chk_reg_index: assert property (I_INSTR_VALID && w[9:6] == GRP_AND && !w[4] |->
		O_REG_RADDR == {~w[5], w[3:0]}) else $error("reg index");
endmodule // tlie_exec_properties

bind tlie_exec tlie_exec_properties u_props (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
	.I_INSTR_VALID(I_INSTR_VALID), .I_INSTR_WORD(I_INSTR_WORD), .I_SECOND_WORD(I_SECOND_WORD),
	.I_REG_RDATA(I_REG_RDATA), .I_ROM_PAGE_CTRL(I_ROM_PAGE_CTRL), .I_ROM_DATA(I_ROM_DATA),
	.I_TABLE_BASE_PAIR(I_TABLE_BASE_PAIR), .I_SW_ADDR(I_SW_ADDR), .I_SW_WDATA(I_SW_WDATA),
	.I_SW_WR(I_SW_WR), .O_REG_RADDR(O_REG_RADDR), .O_ROM_ADDR(O_ROM_ADDR), .O_ACC(O_ACC),
	.O_CARRY(O_CARRY), .O_TIMER(O_TIMER), .O_MOD_A(O_MOD_A), .O_MOD_B(O_MOD_B), .O_DONE(O_DONE),
	.O_PC_STEP(O_PC_STEP), .O_STANDBY(O_STANDBY), .O_STANDBY_COND(O_STANDBY_COND));

// [bench/tb.sv]
// tb: self-checking bench for tlie_exec, random instruction stream plus corner cases.
// assumes the memory model's fixed content patterns; one clock, synchronous reset.
`timescale 1ns/10ps
module tb import tlie_pkg::*; ;
	logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wake = 1'b0, swe = 1'b0, swre = 1'b0;
	logic [9:0] word = '0, second = '0, tmr, ma, mb, romd;
	logic [3:0] pg = '0, sts = '0, swa = '0, acc, rrd, cond;
	logic [7:0] bs = '0;
	logic [15:0] swd = '0, rdat;
	logic [4:0] raddr;
	logic [ROM_ADDR_W-1:0] roma;
	logic [1:0] step;
	logic cy, flag, done, unk, stby;
	logic [3:0] e_acc = '0, e_cond = '0;
	logic [9:0] e_t = '0, e_a = '0, e_b = '0;
	logic e_cy = 1'b0, e_f = 1'b0, e_stb = 1'b0, e_exec = 1'b1, e_any = 1'b0;
	int err_total = 0, cmp_count = 0, cyc = 0;
	logic [9:0] ops [29] = '{OP_RD_TIMER_LO, OP_RD_TIMER_HI, OP_RD_MOD_A_LO, OP_RD_MOD_A_HI,
		OP_RD_MOD_B_LO, OP_RD_MOD_B_HI, OP_WR_TIMER_LO, OP_WR_TIMER_HI, OP_WR_MOD_A_LO,
		OP_WR_MOD_A_HI, OP_WR_MOD_B_LO, OP_WR_MOD_B_HI, OP_LD_TIMER_IMM, OP_LD_MOD_A_IMM,
		OP_LD_MOD_B_IMM, OP_LD_TIMER_TBL, OP_LD_MOD_A_TBL, OP_LD_MOD_B_TBL, OP_STAT_IMM,
		OP_STAT_REG, OP_ALL_ONES, OP_NOP, {GRP_AND, 6'h00}, {GRP_AND, 1'b0, SUB_ROM},
		{GRP_AND, 1'b1, SUB_IMM}, {GRP_OR, 6'h00}, {GRP_OR, 1'b0, SUB_ROM},
		{GRP_OR, 1'b1, SUB_IMM}, {GRP_XOR, 6'h00}};

	tlie_exec DUT (.I_SYS_CLK(clk), .I_RESET(rst), .I_INSTR_VALID(valid), .I_INSTR_WORD(word),
		.I_SECOND_WORD(second), .O_REG_RADDR(raddr), .I_REG_RDATA(rrd), .I_ROM_PAGE_CTRL(pg),
		.I_TABLE_BASE_PAIR(bs), .O_ROM_ADDR(roma), .I_ROM_DATA(romd), .I_STATUS(sts),
		.I_WAKEUP(wake), .I_SW_ADDR(swa), .I_SW_WDATA(swd), .I_SW_WR(swe), .I_SW_RD(swre),
		.O_SW_RDATA(rdat), .O_ACC(acc), .O_CARRY(cy), .O_STATUS_FLAG(flag), .O_TIMER(tmr),
		.O_MOD_A(ma), .O_MOD_B(mb), .O_DONE(done), .O_PC_STEP(step), .O_UNKNOWN(unk),
		.O_STANDBY(stby), .O_STANDBY_COND(cond));
	tlie_mem_model u_mem (.i_reg_raddr(raddr), .o_reg_rdata(rrd), .i_rom_addr(roma),
		.o_rom_data(romd));

	// clock, and table pointers that wander every cycle
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		pg <= 4'($urandom);
		bs <= 8'($urandom);
	end

	// hang guard; the whole run needs about nine hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	function automatic logic [3:0] regf(input logic [4:0] a);
		return 4'(a * 5'h05 + 5'h03);
	endfunction

	// status match as the control word selects: exact, or any common bit
	function automatic logic smatch(input logic [3:0] o);
		return e_any ? ((sts & o) != 4'h0) : (sts == o);
	endfunction

	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (!ok) begin
			err_total++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// software port: one-cycle strobes, read data in the cycle after the strobe
	task automatic swr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		swa <= a;
		swd <= d;
		swe <= 1'b1;
		@(posedge clk);
		swe <= 1'b0;
		if (a == ADDR_ACC) e_acc = d[3:0];
		if (a == ADDR_FLAGS) {e_f, e_cy} = d[1:0];
		if (a == ADDR_CTRL) {e_any, e_exec} = {d[CTRL_ANY_BIT], d[CTRL_EXEC_BIT]};
	endtask

	task automatic swrd(input logic [3:0] a, input logic [15:0] x);
		@(posedge clk);
		swa <= a;
		swre <= 1'b1;
		@(posedge clk);
		swre <= 1'b0;
		#1 chk(rdat === x, "software read");
	endtask

	// issue one instruction, predict its effect, compare after the answer edge
	task automatic run(input logic [9:0] w, input logic [9:0] s);
		logic [3:0] rv, n;
		logic [9:0] rom;
		logic fire, kn, lf;
		logic [1:0] st;
		@(posedge clk);
		valid <= 1'b1;
		word <= w;
		second <= s;
		#1;
		rv = regf({~w[5], w[3:0]});
		rom = 10'({pg[ROM_PAGE_BITS-1:0], bs} * 11'h025 + 11'h00B);
		n = (w[4:0] == SUB_IMM) ? s[3:0] : (w[4] ? (w[5] ? rom[3:0] : rom[7:4]) : rv);
		lf = !w[4] || w[4:0] == SUB_ROM || w[5:0] == {1'b1, SUB_IMM};
		fire = e_exec && !e_stb;
		kn = fire;
		if (fire) case (w)
			OP_RD_TIMER_LO: {e_acc, e_cy} = {e_t[3:0], 1'b0};
			OP_RD_TIMER_HI: {e_acc, e_cy} = {e_t[7:4], 1'b0};
			OP_RD_MOD_A_LO: {e_acc, e_cy} = {e_a[3:0], 1'b0};
			OP_RD_MOD_A_HI: {e_acc, e_cy} = {e_a[7:4], 1'b0};
			OP_RD_MOD_B_LO: {e_acc, e_cy} = {e_b[3:0], 1'b0};
			OP_RD_MOD_B_HI: {e_acc, e_cy} = {e_b[7:4], 1'b0};
			OP_WR_TIMER_LO: e_t[3:0] = e_acc;
			OP_WR_TIMER_HI: e_t[7:4] = e_acc;
			OP_WR_MOD_A_LO: {e_a[3:0], e_cy} = {e_acc, 1'b0};
			OP_WR_MOD_A_HI: {e_a[7:4], e_cy} = {e_acc, 1'b0};
			OP_WR_MOD_B_LO: {e_b[3:0], e_cy} = {e_acc, 1'b0};
			OP_WR_MOD_B_HI: {e_b[7:4], e_cy} = {e_acc, 1'b0};
			OP_LD_TIMER_IMM: e_t = s;
			OP_LD_MOD_A_IMM: e_a = s;
			OP_LD_MOD_B_IMM: e_b = s;
			OP_LD_TIMER_TBL: e_t = rom;
			OP_LD_MOD_A_TBL: e_a = rom;
			OP_LD_MOD_B_TBL: e_b = rom;
			OP_STANDBY: {e_stb, e_cond} = {1'b1, s[3:0]};
			OP_STAT_IMM: e_f = smatch(s[3:0]);
			OP_ALL_ONES: e_cy = (e_acc == 4'hF);
			OP_NOP: ;
			default: begin
				if (w[9:6] == GRP_AND && lf) {e_cy, e_acc} = {e_acc[3] & n[3], e_acc & n};
				else if (w[9:6] == GRP_OR && lf) {e_cy, e_acc} = {1'b0, e_acc | n};
				else if (w[9:6] == GRP_XOR && !w[4]) {e_cy, e_acc} = {e_acc[3] & n[3], e_acc ^ n};
				else if (w[9:4] == 6'h06) e_f = smatch(rv);
				else kn = 1'b0;
			end
		endcase
		st = !kn ? 2'h0 : (w[4:0] == SUB_IMM || w[9:4] == 6'h0D) ? 2'h2 : 2'h1;
		@(posedge clk);
		valid <= 1'b0;
		#1;
		chk({acc, cy, flag, tmr, ma, mb} === {e_acc, e_cy, e_f, e_t, e_a, e_b}, "state");
		chk({done, step, unk, stby, cond} === {kn, st, fire & !kn, e_stb, e_cond}, "sequence");
	endtask

	initial begin
		logic [9:0] w;
		void'($urandom(84560));
		sts = 4'($urandom);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// status synchroniser needs a few cycles to settle after reset
		repeat (6) @(posedge clk);
		#1 chk({acc, cy, flag, tmr, ma, mb, stby, rdat} === '0, "reset values");
		$display("test reset done");
		swr(ADDR_ACC, 16'h000F);
		swrd(ADDR_ACC, 16'h000F);
		swrd(4'hF, 16'h0000);
		run(OP_ALL_ONES, 10'h000);
		swr(ADDR_ACC, 16'h000E);
		run(OP_ALL_ONES, 10'h000);
		$display("test software port and all-ones done");
		run(OP_STAT_IMM, {6'h00, sts});
		run(OP_STAT_IMM, {6'h00, ~sts});
		// second pass of sixteen uses any-common-bit matching
		for (int i = 0; i < 32; i++) begin
			if (i == 16) swr(ADDR_CTRL, 16'h0003);
			run(OP_STAT_REG | 10'(i[3:0]), 10'h000);
		end
		run(OP_STAT_IMM, 10'h00F);
		swr(ADDR_CTRL, 16'h0001);
		$display("test status done");
		repeat (400) begin
			w = ops[$urandom % 29];
			if (w[9:4] == 6'h06 || !w[4] && w[9:6] inside {GRP_AND, GRP_OR, GRP_XOR})
				w = w | (10'($urandom) & 10'h02F);
			if (w[4:0] == SUB_ROM)
				w = w | (10'($urandom) & 10'h020);
			run(w, 10'($urandom));
		end
		swrd(ADDR_TIMER, {6'h00, e_t});
		$display("test random stream done");
		run(OP_STANDBY, 10'h3A5);
		run(OP_RD_TIMER_LO, 10'h000);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		e_stb = 1'b0;
		#1 chk(stby === 1'b0, "wake from standby");
		swr(ADDR_CTRL, 16'h0000);
		run(OP_NOP, 10'h000);
		swr(ADDR_CTRL, 16'h0001);
		run({GRP_XOR, 1'b0, SUB_ROM}, 10'h000);
		run(OP_NOP, 10'h000);
		$display("test standby and refusal done");
		summarize();
	end
endmodule // tb
